// *** rtl/tse_cfg.svh ***
/*
 * constants of the trigger source select block: register map, field
 * positions, reset values and timing counts.
 * assumes a single 25 mhz clock and a 32-bit apb register bus.
 */
`ifndef TSE_CFG_SVH
`define TSE_CFG_SVH
// ==========================================
// register map (byte addresses)
`define TSE_A_CTRL   8'h00
`define TSE_A_DELAY  8'h04
`define TSE_A_STATUS 8'h08
// ==========================================
// control register fields
`define TSE_F_EN     2:0
`define TSE_F_SRC0   6:4
`define TSE_F_SRC1   10:8
`define TSE_F_SRC2   14:12
`define TSE_F_EDGE   17:16
`define TSE_F_INV3   18
`define TSE_F_INV1   19
`define TSE_F_POS    20
`define TSE_F_CCW    21
`define TSE_CTRL_W   22
`define TSE_CTRL_RST 22'h000000
`define TSE_DLY_W    16
`define TSE_DLY_RST  16'h0000
// ==========================================
// timing: one microsecond in clock cycles, rounded up
`define TSE_CLK_NS   40
`define TSE_US_NS    1000
`define TSE_US_CYC   ((`TSE_US_NS + `TSE_CLK_NS - 1) / `TSE_CLK_NS)
// ==========================================
// encoder position mode sizes
`define TSE_REV_MAX  7'h7f
`define TSE_DROP_MAX 8'hff
`endif

// *** rtl/tse_pkg.sv ***
/*
 * types of the trigger source select block.
 * assumes nothing beyond the constants header.
 */
package tse_pkg;
  // trigger source codes
  typedef enum logic [2:0] {
    SRC_PIN_ONE,
    SRC_PIN_THREE,
    SRC_SHAFT,
    SRC_TIMER,
    SRC_TALLY,
    SRC_STAMP,
    SRC_CMD_ONE,
    SRC_CMD_TWO
  } tse_src_t;
  // edge qualification codes
  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_ANY,
    EDGE_RSVD
  } tse_edge_t;
endpackage

// *** rtl/tse_top.sv ***
/*
 * trigger source select: picks a source per trigger type, qualifies
 * line edges, decodes a quadrature encoder and delays the trigger.
 * assumes internal events are one-cycle pulses on clock; pins are async.
 */
// Chosen here: the register addresses and the APB register port.
// What this block does
// RL1: input pin three selectable as trigger source
// RL2: shaft decoder selectable only for row trigger
// RL3: timer expiry only for image triggers
// RL4: tally expiry only for image triggers
// RL5: clock stamp wrap selectable as source
// RL6: broadcast commands trigger image triggers only
// RL7: edge choice applies only to pin sources
// RL8: rising edge after inversion accepts trigger
// RL9: falling edge accepts trigger
// RL10: any edge accepts trigger
// RL11: wait programmed microseconds before trigger pulse
// RL12: position mode keeps 7-bit reverse counter
// RL13: reverse counter saturates, never wraps
// RL14: after saturation drop next 256 forward steps
// RL15: motion mode pulses on every step
// RL16: clockwise means phase b leads a
// RL17: counter-clockwise means phase a leads b
// RL18: input pin one feeds encoder phase a
// RL19: disabled trigger type ignores its source
// RL20: row trigger fires one pulse per line
// RL21: encoder phases synchronised before decoding
`include "tse_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tse_top (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        input_pin_one,
  input  wire logic        input_pin_two,
  input  wire logic        input_pin_three,
  input  wire logic        interval_timer_expiry,
  input  wire logic        event_tally_expiry,
  input  wire logic        clock_stamp_wrap_event,
  input  wire logic        broadcast_command_one,
  input  wire logic        broadcast_command_two,
  output logic      [2:0]  delayed_trigger_pulse
);
  // ==========================================
  // registers
  logic [`TSE_CTRL_W-1:0] ctrl_q;   // enables, sources, options
  logic [`TSE_DLY_W-1:0]  delay_q;  // post_trigger_wait in us
  logic [2:0]  trigger_enable_switch;
  logic [2:0]  src [3];             // per type source code
  logic [1:0]  trigger_edge_choice;
  logic        shaft_decoder_pulse_policy; // 1 position, 0 motion
  logic        shaft_forward_sense;        // 1 counter-clockwise
  assign trigger_enable_switch      = ctrl_q[`TSE_F_EN];
  assign src[0]                     = ctrl_q[`TSE_F_SRC0];
  assign src[1]                     = ctrl_q[`TSE_F_SRC1];
  assign src[2]                     = ctrl_q[`TSE_F_SRC2];
  assign trigger_edge_choice        = ctrl_q[`TSE_F_EDGE];
  assign shaft_decoder_pulse_policy = ctrl_q[`TSE_F_POS];
  assign shaft_forward_sense        = ctrl_q[`TSE_F_CCW];

  // ==========================================
  // pin synchronisers
  logic [2:0] pin_m_q;  // first stage, read only by second
  logic [2:0] pin_s_q;  // safe samples: one, two, three
  // two flops per pin so metastability cannot reach the decoder
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_m_q <= 3'h0;
      pin_s_q <= 3'h0;
    end else begin
      pin_m_q <= {input_pin_three, input_pin_two, input_pin_one}; // RL21
      pin_s_q <= pin_m_q; // RL21
    end
  end

  // ==========================================
  // line edge qualification
  logic [1:0] line_c;   // after inversion: [0] pin one, [1] pin three
  logic [1:0] line_p_q; // previous conditioned level
  logic [1:0] line_rise;
  logic [1:0] line_fall;
  logic [1:0] line_hit; // qualified edge per line
  assign line_c    = {pin_s_q[2] ^ ctrl_q[`TSE_F_INV3], pin_s_q[0] ^ ctrl_q[`TSE_F_INV1]};
  assign line_rise = line_c & ~line_p_q; // RL8
  assign line_fall = ~line_c & line_p_q; // RL9
  // reserved edge code accepts nothing
  assign line_hit  = (trigger_edge_choice == tse_pkg::EDGE_RISE) ? line_rise :
                     (trigger_edge_choice == tse_pkg::EDGE_FALL) ? line_fall :
                     (trigger_edge_choice == tse_pkg::EDGE_ANY)  ? (line_rise | line_fall) : 2'h0; // RL10
  // remember the last level for edge finding
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) line_p_q <= 2'h0;
    else       line_p_q <= line_c;
  end

  // ==========================================
  // quadrature decoder
  logic enc_a, enc_b;     // phases
  logic enc_pa_q, enc_pb_q;
  logic a_chg, b_chg, a_lead, b_lead, fwd_step, rev_step, any_step;
  assign enc_a    = pin_s_q[0]; // RL18
  assign enc_b    = pin_s_q[1];
  assign a_chg    = enc_a ^ enc_pa_q;
  assign b_chg    = enc_b ^ enc_pb_q;
  // a double change is a lost step and counts for nothing
  assign a_lead   = (a_chg & ~b_chg & (enc_a ^ enc_b)) | (b_chg & ~a_chg & ~(enc_a ^ enc_b));
  assign b_lead   = (b_chg & ~a_chg & (enc_a ^ enc_b)) | (a_chg & ~b_chg & ~(enc_a ^ enc_b));
  assign fwd_step = shaft_forward_sense ? a_lead : b_lead; // RL16 RL17
  assign rev_step = shaft_forward_sense ? b_lead : a_lead;
  assign any_step = a_lead | b_lead;

  logic [6:0] rev_q;   // reverse travel
  logic       sat_q;   // saturated excursion seen
  logic [7:0] drop_q;  // forward steps dropped so far
  logic       shaft_q; // shaft_decoder_source pulse
  // position bookkeeping and encoder output pulse
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      enc_pa_q <= 1'b0;
      enc_pb_q <= 1'b0;
      rev_q    <= 7'h00;
      sat_q    <= 1'b0;
      drop_q   <= 8'h00;
      shaft_q  <= 1'b0;
    end else begin
      enc_pa_q <= enc_a;
      enc_pb_q <= enc_b;
      shaft_q  <= 1'b0;
      if (!shaft_decoder_pulse_policy) begin
        shaft_q <= any_step; // RL15
        rev_q   <= 7'h00;
        sat_q   <= 1'b0;
        drop_q  <= 8'h00;
      end else if (rev_step) begin
        // hold at the top rather than wrap
        if (rev_q == `TSE_REV_MAX) sat_q <= 1'b1; // RL13
        else                       rev_q <= rev_q + 7'h01; // RL12
      end else if (fwd_step) begin
        if (sat_q) begin
          // drop a fixed block, then start afresh
          if (drop_q == `TSE_DROP_MAX) begin
            sat_q  <= 1'b0;
            rev_q  <= 7'h00;
            drop_q <= 8'h00;
          end else begin
            drop_q <= drop_q + 8'h01; // RL14
          end
        end else if (rev_q != 7'h00) begin
          rev_q <= rev_q - 7'h01;
        end else begin
          shaft_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // source selection per trigger type
  logic [4:0] int_ev;  // timer, tally, stamp, command one, command two
  assign int_ev = {broadcast_command_two, broadcast_command_one, clock_stamp_wrap_event,
                   event_tally_expiry, interval_timer_expiry};
  // which source fires for one trigger type this cycle
  // every input is an argument: a continuous assignment only wakes on its operands
  function automatic logic src_fire(input logic [2:0] s,
                                    input logic       img,
                                    input logic [1:0] hit,
                                    input logic       shaft,
                                    input logic [4:0] evs);
    case (s)
      tse_pkg::SRC_PIN_ONE:   src_fire = hit[0];         // RL7
      tse_pkg::SRC_PIN_THREE: src_fire = hit[1];         // RL1
      tse_pkg::SRC_SHAFT:     src_fire = !img && shaft;  // RL2
      tse_pkg::SRC_TIMER:     src_fire = img && evs[0];  // RL3
      tse_pkg::SRC_TALLY:     src_fire = img && evs[1];  // RL4
      tse_pkg::SRC_STAMP:     src_fire = evs[2];         // RL5
      tse_pkg::SRC_CMD_ONE:   src_fire = img && evs[3];  // RL6
      tse_pkg::SRC_CMD_TWO:   src_fire = img && evs[4];  // RL6
      default:                src_fire = 1'b0;
    endcase
  endfunction

  // ==========================================
  // per type acceptance and microsecond delay
  logic [2:0] acc;      // accepted this cycle
  logic [2:0] busy_q;   // delay running
  logic [2:0] trig_q;   // delayed_trigger_pulse
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_type
      logic [4:0]            sub_q; // cycles within a microsecond
      logic [`TSE_DLY_W-1:0] us_q;  // microseconds left
      // triggers during a running delay are ignored
      assign acc[k] = trigger_enable_switch[k] && !busy_q[k] &&
                      src_fire(src[k], k != 0, line_hit, shaft_q, int_ev); // RL19
      // count whole microseconds from the accepting edge
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          busy_q[k] <= 1'b0;
          trig_q[k] <= 1'b0;
          sub_q     <= 5'h00;
          us_q      <= 16'h0000;
        end else begin
          trig_q[k] <= 1'b0;
          if (acc[k]) begin
            if (delay_q == 16'h0000) begin
              trig_q[k] <= 1'b1; // RL11
            end else begin
              busy_q[k] <= 1'b1;
              us_q      <= delay_q;
              sub_q     <= 5'h00;
            end
          end else if (busy_q[k]) begin
            if (sub_q == 5'(`TSE_US_CYC - 1)) begin
              sub_q <= 5'h00;
              us_q  <= us_q - 16'h0001;
              if (us_q == 16'h0001) begin
                busy_q[k] <= 1'b0;
                trig_q[k] <= 1'b1; // RL11 RL20
              end
            end else begin
              sub_q <= sub_q + 5'h01;
            end
          end
        end
      end
    end
  endgenerate
  assign delayed_trigger_pulse = trig_q;

  // ==========================================
  // apb slave, one wait state
  logic        acc_ph;
  logic        wr_done;  // write completes: ready seen high with the request
  logic        hit_ctrl, hit_dly, hit_stat;
  logic [31:0] rd_mux;
  assign acc_ph   = psel && penable && !pready;
  assign wr_done  = psel && penable && pready && pwrite;
  assign hit_ctrl = (paddr == `TSE_A_CTRL);
  assign hit_dly  = (paddr == `TSE_A_DELAY);
  assign hit_stat = (paddr == `TSE_A_STATUS);
  // status shows encoder and delay state; reserved bits read zero
  assign rd_mux   = hit_ctrl ? {10'h000, ctrl_q} :
                    hit_dly  ? {16'h0000, delay_q} :
                    hit_stat ? {13'h0000, sat_q, drop_q, rev_q, busy_q} : 32'h0000_0000;
  // answer at the second access edge; a write lands only at the completing edge,
  // so an aborted access can never change a register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl_q  <= `TSE_CTRL_RST;
      delay_q <= `TSE_DLY_RST;
    end else begin
      pready  <= acc_ph;
      pslverr <= acc_ph && !(hit_ctrl || hit_dly || hit_stat);
      if (acc_ph && !pwrite) prdata <= rd_mux;
      if (wr_done && hit_ctrl) ctrl_q <= pwdata[`TSE_CTRL_W-1:0];
      if (wr_done && hit_dly)  delay_q <= pwdata[`TSE_DLY_W-1:0];
    end
  end

  // ==========================================
  // checks
  // cycles since the last image accept; holds at the top
  logic [6:0] img_age_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)                                          img_age_q <= 7'h00;
    else if (acc[1])                                    img_age_q <= 7'h01;
    else if (img_age_q != 7'h00 && img_age_q != 7'h7f) img_age_q <= img_age_q + 7'h01;
  end
  a_off_ignored: assert property (@(posedge clock) disable iff (!nrst) // RL19
    !trigger_enable_switch[0] |-> !acc[0]) else $error("disabled row trigger accepted");
  a_shaft_row_only: assert property (@(posedge clock) disable iff (!nrst) // RL2
    acc[1] |-> src[1] != tse_pkg::SRC_SHAFT) else $error("shaft source fired image trigger");
  a_timer_not_row: assert property (@(posedge clock) disable iff (!nrst) // RL3
    acc[0] |-> src[0] != tse_pkg::SRC_TIMER) else $error("timer fired row trigger");
  a_rise_qual: assert property (@(posedge clock) disable iff (!nrst) // RL8
    (acc[1] && src[1] == tse_pkg::SRC_PIN_THREE && trigger_edge_choice == tse_pkg::EDGE_RISE)
    |-> line_c[1] && !$past(line_c[1])) else $error("rise accept without rising line");
  a_fall_qual: assert property (@(posedge clock) disable iff (!nrst) // RL9
    (acc[1] && src[1] == tse_pkg::SRC_PIN_THREE && trigger_edge_choice == tse_pkg::EDGE_FALL)
    |-> !line_c[1] && $past(line_c[1])) else $error("fall accept without falling line");
  a_stamp_no_edge: assert property (@(posedge clock) disable iff (!nrst) // RL7
    (trigger_enable_switch[0] && !busy_q[0] && src[0] == tse_pkg::SRC_STAMP && clock_stamp_wrap_event)
    |-> acc[0]) else $error("stamp event lost");
  a_zero_delay: assert property (@(posedge clock) disable iff (!nrst) // RL11
    (acc[2] && delay_q == 16'h0000) |=> trig_q[2] ##1 !trig_q[2]) else $error("zero delay pulse wrong");
  a_two_us_delay: assert property (@(posedge clock) disable iff (!nrst) // RL11
    (acc[1] && delay_q == 16'h0002) |-> ##51 trig_q[1]) else $error("two us delay pulse missing");
  a_no_early_pulse: assert property (@(posedge clock) disable iff (!nrst) // RL11
    (trig_q[1] && delay_q == 16'h0002 && img_age_q != 7'h00) |-> img_age_q == 7'h33)
    else $error("two us delay pulse early");
  a_rev_sat: assert property (@(posedge clock) disable iff (!nrst) // RL13
    (shaft_decoder_pulse_policy && rev_step && rev_q == `TSE_REV_MAX) |=> rev_q == `TSE_REV_MAX && sat_q)
    else $error("reverse counter wrapped");
  a_motion_out: assert property (@(posedge clock) disable iff (!nrst) // RL15
    (!shaft_decoder_pulse_policy && any_step) |=> shaft_q) else $error("motion step gave no pulse");
endmodule
`default_nettype wire

// *** verif/tse_enc_model.sv ***
/*
 * quadrature shaft encoder model driving the two phase pins.
 * assumes the bench calls step from its own process only.
 */
`timescale 1ns/1ns
`default_nettype none
module tse_enc_model (
  input  wire logic clock,
  output logic      phase_a,
  output logic      phase_b
);
  // ==========
  // gray position; a-leading order is 00, 10, 11, 01
  logic [1:0] idx = 2'h0;
  initial {phase_a, phase_b} = 2'h0;
  // one step moves one phase only, then holds long enough for the synchroniser
  task automatic step(input logic a_lead);
    begin
      @(posedge clock);
      idx = a_lead ? idx + 2'h1 : idx - 2'h1;
      {phase_a, phase_b} <= {idx[1] ^ idx[0], idx[1]};
      repeat (3) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// *** verif/trigger_source_encoder_select_tb_top.sv ***
/*
 * self-checking bench for the trigger source select block.
 * assumes the apb map and field layout of tse_cfg.svh and one clock.
 */
`include "tse_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module trigger_source_encoder_select_tb_top;
  // ==========
  // stimulus and observation
  logic        clock, nrst, psel, penable, pwrite, pready, pslverr, err, ph_a, ph_b, pin_three;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ev_tmr, ev_tly, ev_stp, ev_c1, ev_c2; // internal event pulses
  logic [2:0]  dtp;    // row, image, multi image pulses
  int          n_fail, compares, lat0, latn, c0, c1, c2;
  int          cnt[3]; // pulses seen per trigger type
  tse_top i_dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .input_pin_one(ph_a), .input_pin_two(ph_b), .input_pin_three(pin_three),
    .interval_timer_expiry(ev_tmr), .event_tally_expiry(ev_tly), .clock_stamp_wrap_event(ev_stp),
    .broadcast_command_one(ev_c1), .broadcast_command_two(ev_c2), .delayed_trigger_pulse(dtp));
  tse_enc_model i_enc (.clock(clock), .phase_a(ph_a), .phase_b(ph_b));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // counts pulses; tests judge by differences so no second writer is needed
  always @(posedge clock) begin
    for (int i = 0; i < 3; i++) if (dtp[i] === 1'b1) cnt[i]++;
  end
  // ==========
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk("apb wait", 32'h2, n);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] cw(input logic [2:0] en, s0, s1, s2, input logic [1:0] ed,
                                     input logic [3:0] fl);
    return {10'h0, fl, ed, 1'b0, s2, 1'b0, s1, 1'b0, s0, 1'b0, en};
  endfunction
  // drive one internal event line by number
  task automatic ev_set(input int i, input logic v);
    case (i)
      0:       ev_tmr <= v;
      1:       ev_tly <= v;
      2:       ev_stp <= v;
      3:       ev_c1 <= v;
      default: ev_c2 <= v;
    endcase
  endtask
  task automatic ev_pulse(input int i);
    @(posedge clock);
    ev_set(i, 1'b1);
    @(posedge clock);
    ev_set(i, 1'b0);
  endtask
  task automatic snap();
    c0 = cnt[0];
    c1 = cnt[1];
    c2 = cnt[2];
  endtask
  // latency of the image trigger from a timer pulse; a retrigger while busy must be dropped
  task automatic measure(output int lat);
    lat = 0;
    ev_pulse(0);
    while (dtp[1] !== 1'b1 && lat < 200) begin
      @(posedge clock);
      lat++;
      if (lat == 10) ev_tmr <= 1'b1;
      if (lat == 11) ev_tmr <= 1'b0;
    end
    repeat (60) @(posedge clock);
  endtask
  // ==========
  // scenarios
  task automatic t_regs();
    apb(1'b0, `TSE_A_CTRL, 32'h0);
    chk("ctrl reset", {10'h0, `TSE_CTRL_RST}, rd);
    apb(1'b1, `TSE_A_DELAY, 32'h1234);
    apb(1'b0, `TSE_A_DELAY, 32'h0);
    chk("delay rw", 32'h1234, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, `TSE_A_DELAY, 32'h0);
    $display("test regs done");
  endtask
  // pin three as image source; set up disabled first so an inversion flip is not an edge
  task automatic t_edge(input logic [1:0] ed, input logic inv, input int hi, input int lo);
    apb(1'b1, `TSE_A_CTRL, cw(3'h0, 3'h1, 3'h1, 3'h1, ed, {3'h0, inv}));
    repeat (6) @(posedge clock);
    apb(1'b1, `TSE_A_CTRL, cw(3'h2, 3'h1, 3'h1, 3'h1, ed, {3'h0, inv}));
    snap();
    pin_three <= 1'b1;
    repeat (8) @(posedge clock);
    chk("edge after rise", hi, cnt[1] - c1);
    pin_three <= 1'b0;
    repeat (8) @(posedge clock);
    chk("edge after fall", lo, cnt[1] - c1);
    $display("test edge %0d inv %0d done", ed, inv);
  endtask
  task automatic t_delay();
    apb(1'b1, `TSE_A_CTRL, cw(3'h3, 3'h3, 3'h3, 3'h0, 2'h3, 4'h0));
    snap();
    measure(lat0);
    apb(1'b1, `TSE_A_DELAY, 32'h2);
    measure(latn);
    chk("delay cycles", 32'd50, latn - lat0);
    chk("timer on row", 32'h0, cnt[0] - c0);
    chk("image pulses", 32'h2, cnt[1] - c1);
    apb(1'b1, `TSE_A_DELAY, 32'h0);
    $display("test delay done");
  endtask
  // internal sources on row and multi image, image type disabled, edge choice none
  task automatic t_int();
    for (int c = 3; c < 8; c++) begin
      apb(1'b1, `TSE_A_CTRL, cw(3'h5, c[2:0], c[2:0], c[2:0], 2'h3, 4'h0));
      snap();
      ev_pulse(c - 3);
      repeat (6) @(posedge clock);
      chk("row internal", (c == 5) ? 32'h1 : 32'h0, cnt[0] - c0);
      chk("image disabled", 32'h0, cnt[1] - c1);
      chk("multi internal", 32'h1, cnt[2] - c2);
    end
    $display("test internal done");
  endtask
  task automatic t_motion();
    apb(1'b1, `TSE_A_CTRL, cw(3'h3, 3'h2, 3'h2, 3'h0, 2'h0, 4'h0));
    snap();
    for (int i = 0; i < 8; i++) i_enc.step(i >= 4);
    repeat (8) @(posedge clock);
    chk("motion row", 32'h8, cnt[0] - c0);
    chk("shaft on image", 32'h0, cnt[1] - c1);
    $display("test motion done");
  endtask
  task automatic t_position();
    apb(1'b1, `TSE_A_CTRL, cw(3'h1, 3'h2, 3'h0, 3'h0, 2'h0, 4'h4));
    snap();
    repeat (3) i_enc.step(1'b0);
    repeat (127) i_enc.step(1'b1);
    repeat (4) @(posedge clock);
    chk("forward cw", 32'h3, cnt[0] - c0);
    apb(1'b0, `TSE_A_STATUS, 32'h0);
    chk("reverse count", {25'h0, `TSE_REV_MAX}, {25'h0, rd[9:3]});
    chk("not saturated", 32'h0, {31'h0, rd[18]});
    i_enc.step(1'b1);
    apb(1'b0, `TSE_A_STATUS, 32'h0);
    chk("saturated", 32'h1, {31'h0, rd[18]});
    chk("count held", {25'h0, `TSE_REV_MAX}, {25'h0, rd[9:3]});
    snap();
    repeat (256) i_enc.step(1'b0);
    chk("dropped lines", 32'h0, cnt[0] - c0);
    repeat (2) i_enc.step(1'b0);
    repeat (4) @(posedge clock);
    chk("resumed lines", 32'h2, cnt[0] - c0);
    apb(1'b1, `TSE_A_CTRL, cw(3'h1, 3'h2, 3'h0, 3'h0, 2'h0, 4'hc));
    snap();
    i_enc.step(1'b0);
    i_enc.step(1'b1);
    i_enc.step(1'b1);
    repeat (4) @(posedge clock);
    chk("forward ccw", 32'h1, cnt[0] - c0);
    $display("test position done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    {nrst, psel, penable, pwrite, pin_three} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {ev_tmr, ev_tly, ev_stp, ev_c1, ev_c2} = 5'h00;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_edge(2'h0, 1'b0, 1, 1);
    t_edge(2'h1, 1'b0, 0, 1);
    t_edge(2'h2, 1'b0, 1, 2);
    t_edge(2'h0, 1'b1, 0, 1);
    t_edge(2'h3, 1'b0, 0, 0);
    t_delay();
    t_int();
    t_motion();
    t_position();
    tally_and_finish();
  end
  // whole run is about 2100 cycles; the limit leaves wide margin
  initial begin
    #(40 * 20000);
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
